// *** verilog/itg_timecode_gen.sv ***
// itg_timecode_gen: internal timecode counter with user bits, jam, restart,
// startup initialisation and auto-record delay, reached over APB.
// assumes frameTick pulses once per frame at the selected rate's timebase.
//
// Functional notes
// - user bits are eight hex digits carried with the count
// - all-user format: all four groups come from software
// - month-day-year format: rtc fills first three groups, last is user
// - day-month-year format: rtc fills first three groups, last is user
// - year-month-day format: rtc fills first three groups, last is user
// - 23.976 non-drop counts every frame, timebase runs 0.1 percent slow
// - 24, 25 and 30 non-drop count every frame number in turn
// - 29.97 non-drop counts every frame, lagging real time 0.1 percent
// - 29.97 drop skips frame numbers to track real time
// - 30 drop applies drop numbering at true 30 frames per second
// - jam loads the count from the decoded external timecode
// - restart loads the preset and keeps running from it
// - auto record, in external mode only, waits a set delay after external timecode arrives
// - every startup jams the count from the chosen source
// - restart source: preset loaded at startup
// - rtc source: saved count advanced by elapsed rtc seconds
// - external mode: count chases the external timecode
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module itg_timecode_gen #(
    parameter int DELAY_W = 16
) (
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    input  wire itg_pkg::itg_apb_req_type apbReq,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    input  wire logic                   frameTick,
    input  wire itg_pkg::itg_tc_type    extTc,
    input  wire logic                   extValid,
    input  wire itg_pkg::itg_date_type  rtcDate,
    output itg_pkg::itg_tc_type         tcOut,
    output logic [31:0]                 ubitsOut,
    output logic                        recordGo,
    output logic                        initBusy
);
    import itg_pkg::*;

    typedef enum logic [1:0] {ST_STOP, ST_ADVANCE, ST_RUN} itg_phase_type;

    typedef struct packed {
        itg_phase_type          phase;
        itg_tc_type             tc;
        itg_tc_type             preset;
        itg_tc_type             saved;
        logic [ELAPSED_W-1:0]   elapsedSet;
        logic [ELAPSED_W-1:0]   elapsedLeft;
        itg_rate_type           rate;
        itg_fmt_type            fmt;
        logic                   initRtc;
        logic                   extMode;
        logic                   run;
        logic                   runPrev;
        logic                   initBusy;
        logic [31:0]            user;
        logic [31:0]            ubits;
        logic [DELAY_W-1:0]     delay;
        logic [DELAY_W-1:0]     delayCnt;
        logic                   recordGo;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
    } itg_state_type;

    itg_state_type st;
    itg_state_type next_st;
    logic          access;
    logic          wrEn;
    logic          jamReq;
    logic          restartReq;
    logic          mapped;
    logic [31:0]   rdWord;

    // last frame number of the second for a rate
    function automatic logic [4:0] max_frame(input itg_rate_type r);
        case (r)
            R23976ND, R24ND: max_frame = 5'd23;
            R25ND:           max_frame = 5'd24;
            default:         max_frame = 5'd29;
        endcase
    endfunction : max_frame

    function automatic logic is_drop(input itg_rate_type r);
        is_drop = (r == R2997D) || (r == R30D);
    endfunction : is_drop

    // move a dropped frame number on to frame 2
    function automatic itg_tc_type drop_fix(input itg_tc_type t, input itg_rate_type r);
        drop_fix = t;
        if (is_drop(r) && t.frames < 5'd2 && t.seconds == 6'd0 && (t.minutes % 6'd10) != 6'd0)
            drop_fix.frames = 5'd2;
    endfunction : drop_fix

    // one second forward with carry and wrap after 23:59:59
    function automatic itg_tc_type sec_step(input itg_tc_type t);
        sec_step = t;
        if (t.seconds != 6'd59) begin
            sec_step.seconds = t.seconds + 6'd1;
        end else begin
            sec_step.seconds = 6'd0;
            if (t.minutes != 6'd59) begin
                sec_step.minutes = t.minutes + 6'd1;
            end else begin
                sec_step.minutes = 6'd0;
                sec_step.hours = (t.hours == 5'd23) ? 5'd0 : t.hours + 5'd1;
            end
        end
    endfunction : sec_step

    // one frame forward; every number counted unless dropped
    function automatic itg_tc_type tc_next(input itg_tc_type t, input itg_rate_type r);
        itg_tc_type n;
        n = t;
        if (t.frames < max_frame(r)) begin
            n.frames = t.frames + 5'd1;
        end else begin
            n = sec_step(t);
            n.frames = 5'd0;
        end
        tc_next = drop_fix(n, r);
    endfunction : tc_next

    function automatic itg_tc_type word_to_tc(input logic [31:0] w);
        word_to_tc.hours   = w[TC_HR_LSB +: 5];
        word_to_tc.minutes = w[TC_MI_LSB +: 6];
        word_to_tc.seconds = w[TC_SE_LSB +: 6];
        word_to_tc.frames  = w[TC_FR_LSB +: 5];
    endfunction : word_to_tc

    function automatic logic [31:0] tc_to_word(input itg_tc_type t);
        tc_to_word = 32'h0000_0000;
        tc_to_word[TC_HR_LSB +: 5] = t.hours;
        tc_to_word[TC_MI_LSB +: 6] = t.minutes;
        tc_to_word[TC_SE_LSB +: 6] = t.seconds;
        tc_to_word[TC_FR_LSB +: 5] = t.frames;
    endfunction : tc_to_word

    // apb decode: one wait state, write lands at the completing edge
    assign access     = apbReq.psel & apbReq.penable;
    assign wrEn       = access & st.pready & apbReq.pwrite & mapped;
    assign jamReq     = wrEn & (apbReq.paddr == REG_CMD) & apbReq.pwdata[CMD_JAM_BIT];
    assign restartReq = wrEn & (apbReq.paddr == REG_CMD) & apbReq.pwdata[CMD_RST_BIT];

    // read mux and address map
    always_comb begin
        mapped = 1'b1;
        rdWord = 32'h0000_0000;
        case (apbReq.paddr)
            REG_CTRL: begin
                rdWord[CTRL_RATE_LSB +: 3] = st.rate;
                rdWord[CTRL_FMT_LSB +: 2]  = st.fmt;
                rdWord[CTRL_SRC_BIT]       = st.initRtc;
                rdWord[CTRL_EXT_BIT]       = st.extMode;
                rdWord[CTRL_RUN_BIT]       = st.run;
            end
            REG_CMD:     rdWord = 32'h0000_0000;
            REG_UBITS:   rdWord = st.user;
            REG_PRESET:  rdWord = tc_to_word(st.preset);
            REG_SAVED:   rdWord = tc_to_word(st.saved);
            REG_ELAPSED: rdWord[ELAPSED_W-1:0] = st.elapsedSet;
            REG_DELAY:   rdWord[DELAY_W-1:0] = st.delay;
            REG_COUNT:   rdWord = tc_to_word(st.tc);
            REG_UBOUT:   rdWord = st.ubits;
            REG_STATUS:  rdWord = {28'h0000000, extValid, st.recordGo,
                                   st.phase == ST_ADVANCE, st.phase == ST_RUN};
            default:     mapped = 1'b0;
        endcase
    end

    // next state of the whole block
    always_comb begin
        next_st = st;
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        if (access && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.prdata  = rdWord;
            next_st.pslverr = ~mapped;
        end
        if (wrEn) begin
            case (apbReq.paddr)
                REG_CTRL: begin
                    next_st.rate    = itg_rate_type'(apbReq.pwdata[CTRL_RATE_LSB +: 3]);
                    next_st.fmt     = itg_fmt_type'(apbReq.pwdata[CTRL_FMT_LSB +: 2]);
                    next_st.initRtc = apbReq.pwdata[CTRL_SRC_BIT];
                    next_st.extMode = apbReq.pwdata[CTRL_EXT_BIT];
                    next_st.run     = apbReq.pwdata[CTRL_RUN_BIT];
                end
                REG_UBITS:   next_st.user = apbReq.pwdata;
                REG_PRESET:  next_st.preset = word_to_tc(apbReq.pwdata);
                REG_SAVED:   next_st.saved = word_to_tc(apbReq.pwdata);
                REG_ELAPSED: next_st.elapsedSet = apbReq.pwdata[ELAPSED_W-1:0];
                REG_DELAY:   next_st.delay = apbReq.pwdata[DELAY_W-1:0];
                default:     next_st.user = st.user;
            endcase
        end

        // startup jam on each rising run bit, stop on falling
        next_st.runPrev = st.run;
        if (st.run && !st.runPrev) begin
            if (st.initRtc) begin
                next_st.tc          = st.saved;
                next_st.elapsedLeft = st.elapsedSet;
                next_st.phase       = ST_ADVANCE;
            end else begin
                next_st.tc    = drop_fix(st.preset, st.rate);
                next_st.phase = ST_RUN;
            end
        end else if (!st.run) begin
            next_st.phase = ST_STOP;
        end else begin
            case (st.phase)
                ST_ADVANCE: begin
                    // one rtc second per clock; ticks meanwhile are not counted
                    if (st.elapsedLeft != '0) begin
                        next_st.tc          = sec_step(st.tc);
                        next_st.elapsedLeft = st.elapsedLeft - 1'b1;
                    end else begin
                        next_st.tc    = drop_fix(st.tc, st.rate);
                        next_st.phase = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (jamReq)
                        next_st.tc = drop_fix(extTc, st.rate);
                    else if (restartReq)
                        next_st.tc = drop_fix(st.preset, st.rate);
                    else if (st.extMode && extValid)
                        next_st.tc = drop_fix(extTc, st.rate);
                    else if (frameTick)
                        next_st.tc = tc_next(st.tc, st.rate);
                    else
                        next_st.tc = drop_fix(st.tc, st.rate);
                end
                default: next_st.phase = ST_STOP;
            endcase
        end

        // advance flag registered together with the phase it reports
        next_st.initBusy = (next_st.phase == ST_ADVANCE);

        // auto record in external mode after the delay in frames of present external code
        if (st.extMode && extValid) begin
            if (frameTick && st.delayCnt < st.delay)
                next_st.delayCnt = st.delayCnt + 1'b1;
            next_st.recordGo = (st.delayCnt >= st.delay);
        end else begin
            next_st.delayCnt = '0;
            next_st.recordGo = 1'b0;
        end

        // user-bit groups, first group in the top byte
        case (st.fmt)
            UB_MDY:  next_st.ubits = {rtcDate.month, rtcDate.day, rtcDate.year,
                                      st.user[7:0]};
            UB_DMY:  next_st.ubits = {rtcDate.day, rtcDate.month, rtcDate.year,
                                      st.user[7:0]};
            UB_YMD:  next_st.ubits = {rtcDate.year, rtcDate.month, rtcDate.day,
                                      st.user[7:0]};
            default: next_st.ubits = st.user;
        endcase
    end

    // state register, synchronous reset
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st         <= '0;
            st.phase   <= ST_STOP;
            st.rate    <= itg_rate_type'(RATE_RESET);
            st.fmt     <= UB_USER;
            st.user    <= UBITS_RESET;
            st.ubits   <= UBITS_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign pready   = st.pready;
    assign prdata   = st.prdata;
    assign pslverr  = st.pslverr;
    assign tcOut    = st.tc;
    assign ubitsOut = st.ubits;
    assign recordGo = st.recordGo;
    assign initBusy = st.initBusy;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_jam_loads_ext: assert property (
        st.phase == ST_RUN && st.run && jamReq |=> tcOut == drop_fix($past(extTc), st.rate))
        else $error("jam did not load external timecode");
    a_restart_preset: assert property (
        st.phase == ST_RUN && st.run && restartReq && !jamReq
        |=> tcOut == drop_fix(st.preset, st.rate))
        else $error("restart did not load preset");
    a_startup_preset: assert property (
        st.run && !st.runPrev && !st.initRtc
        |=> st.phase == ST_RUN && tcOut == drop_fix($past(st.preset), $past(st.rate)))
        else $error("startup did not load preset");
    a_startup_rtc: assert property (
        st.run && !st.runPrev && st.initRtc
        |=> initBusy && tcOut == $past(st.saved) && st.elapsedLeft == $past(st.elapsedSet))
        else $error("rtc startup did not restore saved count");
    a_user_groups: assert property (
        st.fmt == UB_USER && $stable(st.fmt) |=> ubitsOut == $past(st.user))
        else $error("user format bits wrong");
    a_mdy_groups: assert property (
        st.fmt == UB_MDY |=> ubitsOut[31:8] == {$past(rtcDate.month), $past(rtcDate.day),
                                                $past(rtcDate.year)})
        else $error("month-day-year bits wrong");
    a_ymd_uu: assert property (
        st.fmt == UB_YMD |=> ubitsOut == {$past(rtcDate.year), $past(rtcDate.month),
                                          $past(rtcDate.day), $past(st.user[7:0])})
        else $error("year-month-day bits wrong");
    a_dmy_groups: assert property (
        st.fmt == UB_DMY |=> ubitsOut == {$past(rtcDate.day), $past(rtcDate.month),
                                          $past(rtcDate.year), $past(st.user[7:0])})
        else $error("day-month-year bits wrong");
    a_frame_wrap: assert property (
        st.phase == ST_RUN && st.run && frameTick && !wrEn && !(st.extMode && extValid)
        && st.tc.frames == max_frame(st.rate)
        |=> tcOut.frames == 5'd0 || (is_drop(st.rate) && tcOut.frames == 5'd2))
        else $error("frame count did not wrap at last frame");
    a_drop_skip: assert property (
        st.phase == ST_RUN && $past(st.phase) == ST_RUN && $stable(st.rate)
        && is_drop(st.rate) && tcOut.frames < 5'd2 |-> tcOut.seconds != 6'd0
        || (tcOut.minutes % 6'd10) == 6'd0)
        else $error("dropped frame number shown");
    a_ext_chase: assert property (
        st.phase == ST_RUN && st.run && st.extMode && extValid && !wrEn
        |=> tcOut == drop_fix($past(extTc), st.rate))
        else $error("count not chasing external timecode");
    a_rec_delay: assert property (
        !(st.extMode && extValid) |=> !recordGo ##0 (st.delayCnt == '0))
        else $error("record started without external timecode");
endmodule : itg_timecode_gen

// *** verilog/itg_pkg.sv ***
// itg_pkg: constants and types for the internal timecode generator.
// assumes an APB master with 32-bit data and an external frame timebase.
package itg_pkg;
    // register byte offsets
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_CMD     = 8'h04;
    localparam logic [7:0]  REG_UBITS   = 8'h08;
    localparam logic [7:0]  REG_PRESET  = 8'h0c;
    localparam logic [7:0]  REG_SAVED   = 8'h10;
    localparam logic [7:0]  REG_ELAPSED = 8'h14;
    localparam logic [7:0]  REG_DELAY   = 8'h18;
    localparam logic [7:0]  REG_COUNT   = 8'h1c;
    localparam logic [7:0]  REG_UBOUT   = 8'h20;
    localparam logic [7:0]  REG_STATUS  = 8'h24;
    // control and command field positions
    localparam int          CTRL_RATE_LSB = 0;
    localparam int          CTRL_FMT_LSB  = 4;
    localparam int          CTRL_SRC_BIT  = 6;
    localparam int          CTRL_EXT_BIT  = 7;
    localparam int          CTRL_RUN_BIT  = 8;
    localparam int          CMD_JAM_BIT   = 0;
    localparam int          CMD_RST_BIT   = 1;
    // timecode word field positions
    localparam int          TC_FR_LSB = 0;
    localparam int          TC_SE_LSB = 8;
    localparam int          TC_MI_LSB = 16;
    localparam int          TC_HR_LSB = 24;
    // reset values and widths
    localparam logic [2:0]  RATE_RESET  = 3'h5;
    localparam logic [31:0] UBITS_RESET = 32'h0000_0000;
    localparam int          ELAPSED_W   = 17;

    typedef enum logic [2:0] {
        R23976ND, R24ND, R25ND, R2997ND, R2997D, R30ND, R30D
    } itg_rate_type;

    typedef enum logic [1:0] {UB_USER, UB_MDY, UB_DMY, UB_YMD} itg_fmt_type;

    typedef struct packed {
        logic [4:0] hours;
        logic [5:0] minutes;
        logic [5:0] seconds;
        logic [4:0] frames;
    } itg_tc_type;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
    } itg_date_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } itg_apb_req_type;
endpackage : itg_pkg

// *** verification/itg_ext_source.sv ***
// itg_ext_source: model of the external timecode decoder feeding the generator.
// assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module itg_ext_source
    import itg_pkg::*;
(
    input  wire logic         ref_clk,
    output itg_pkg::itg_tc_type extTc,
    output logic              extValid
);
    itg_tc_type held = '0;
    logic       flip = 1'b0;

    // a lost source leaves no stale value on the decoder output
    always @(posedge ref_clk) begin
        flip <= ~flip;
    end
    assign extTc = extValid ? held : (flip ? ~held : {11{2'b10}});

    initial begin
        extValid = 1'b0;
    end

    // present a decoded timecode
    task automatic drive_tc(input itg_tc_type t);
        held     <= t;
        extValid <= 1'b1;
    endtask : drive_tc

    // timecode stops arriving
    task automatic drop_tc();
        extValid <= 1'b0;
    endtask : drop_tc
endmodule : itg_ext_source

// *** verification/testbench.sv ***
// testbench: self-checking bench for the internal timecode generator.
// assumes one apb master here and the decoder model on the external input.
`timescale 1ns/1ps
module testbench;
    import itg_pkg::*;
    typedef struct packed {
        logic [2:0]  rate;
        logic [1:0]  fmt;
        itg_tc_type  preset;
        itg_tc_type  expTc;
        logic [31:0] expUb;
    } itg_row_type;

    logic            ref_clk        = 1'b0;
    logic            reset_n        = 1'b0;
    itg_apb_req_type apbReq         = '0;
    logic            frameTick      = 1'b0;
    itg_date_type    rtcDate        = '{8'h24, 8'h07, 8'h19};
    logic            pready, pslverr, recordGo, initBusy, extValid, err;
    logic [31:0]     prdata, ubitsOut, rd;
    itg_tc_type      tcOut, extTc;
    itg_row_type     rows [8];
    int              nErrors        = 0;
    int              samplesChecked = 0;

    // 10 MHz reference clock
    always #50 ref_clk = ~ref_clk;

    itg_timecode_gen i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .apbReq(apbReq),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .frameTick(frameTick),
        .extTc(extTc), .extValid(extValid), .rtcDate(rtcDate), .tcOut(tcOut),
        .ubitsOut(ubitsOut), .recordGo(recordGo), .initBusy(initBusy));
    itg_ext_source i_src (.ref_clk(ref_clk), .extTc(extTc), .extValid(extValid));

    function automatic itg_tc_type tc(input logic [7:0] h, m, s, f);
        return '{h[4:0], m[5:0], s[5:0], f[4:0]};
    endfunction : tc
    function automatic logic [31:0] tcw(input itg_tc_type t);
        return {3'h0, t.hours, 2'h0, t.minutes, 2'h0, t.seconds, 3'h0, t.frames};
    endfunction : tcw
    function automatic logic [31:0] ctrlw(input logic run, ext, src,
                                          input logic [1:0] fmt, input logic [2:0] rate);
        return {23'h0, run, ext, src, fmt, 1'b0, rate};
    endfunction : ctrlw

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic chk(input logic [31:0] got, exp, input string msg);
        samplesChecked++;
        if (got !== exp) begin
            $display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp);
            nErrors++;
        end
    endtask : chk
    // apb transfer: setup, access, hold until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        apbReq <= '{1'b1, 1'b0, wr, addr, wd};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
        chk(32'(n), 32'h2, "apb wait states");
        @(posedge ref_clk);
    endtask : apb
    task automatic tick();
        frameTick <= 1'b1;
        @(posedge ref_clk);
        frameTick <= 1'b0;
        cyc(2);
    endtask : tick
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        cyc(20000);
        nErrors++;
        finish_test();
    end

    // main sequence
    initial begin
        rows[0] = '{3'h0, 2'h0, tc(0, 0, 8'h3b, 8'h17), tc(0, 1, 0, 0), 32'h1234_5678};
        rows[1] = '{3'h1, 2'h1, tc(0, 0, 8'h3b, 8'h17), tc(0, 1, 0, 0), 32'h0719_2478};
        rows[2] = '{3'h2, 2'h2, tc(0, 0, 8'h3b, 8'h18), tc(0, 1, 0, 0), 32'h1907_2478};
        rows[3] = '{3'h3, 2'h3, tc(0, 0, 8'h3b, 8'h1d), tc(0, 1, 0, 0), 32'h2407_1978};
        rows[4] = '{3'h5, 2'h0, tc(0, 0, 8'h3b, 8'h1d), tc(0, 1, 0, 0), 32'h1234_5678};
        rows[5] = '{3'h4, 2'h1, tc(0, 0, 8'h3b, 8'h1d), tc(0, 1, 0, 2), 32'h0719_2478};
        rows[6] = '{3'h6, 2'h2, tc(0, 9, 8'h3b, 8'h1d), tc(0, 8'h0a, 0, 0), 32'h1907_2478};
        rows[7] = '{3'h4, 2'h3, tc(8'h17, 8'h3b, 8'h3b, 8'h1d), tc(0, 0, 0, 0), 32'h2407_1978};
        cyc(5);
        reset_n <= 1'b1;
        cyc(1);
        apb(1'b1, REG_UBITS, 32'h1234_5678);
        // rate and user-bit table, each row started up from its preset by setting run
        foreach (rows[i]) begin
            apb(1'b1, REG_PRESET, tcw(rows[i].preset));
            apb(1'b1, REG_CTRL, ctrlw(1'b0, 1'b0, 1'b0, rows[i].fmt, rows[i].rate));
            apb(1'b1, REG_CTRL, ctrlw(1'b1, 1'b0, 1'b0, rows[i].fmt, rows[i].rate));
            cyc(3);
            chk({10'h0, tcOut}, {10'h0, rows[i].preset}, "startup load");
            tick();
            chk({10'h0, tcOut}, {10'h0, rows[i].expTc}, "frame step");
            chk(ubitsOut, rows[i].expUb, "user bits");
            apb(1'b0, REG_UBOUT, 32'h0);
            chk(rd, rows[i].expUb, "user bits read");
        end
        $display("test table done");
        // second reset in mid-run, then register defaults and an unmapped place
        reset_n <= 1'b0;
        cyc(2);
        reset_n <= 1'b1;
        cyc(1);
        chk({10'h0, tcOut}, 32'h0, "tc after reset");
        chk({30'h0, recordGo, initBusy}, 32'h0, "flags after reset");
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h0000_0005, "ctrl default");
        apb(1'b0, 8'h3c, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        $display("test reset done");
        // jam and restart while running
        apb(1'b1, REG_PRESET, tcw(tc(1, 2, 3, 4)));
        apb(1'b1, REG_CTRL, ctrlw(1'b1, 1'b0, 1'b0, 2'h0, 3'h5));
        cyc(3);
        i_src.drive_tc(tc(0, 3, 8'h22, 8'h14));
        apb(1'b1, REG_CMD, 32'h1);
        cyc(2);
        chk({10'h0, tcOut}, {10'h0, tc(0, 3, 8'h22, 8'h14)}, "jam");
        apb(1'b1, REG_CMD, 32'h2);
        cyc(2);
        chk({10'h0, tcOut}, {10'h0, tc(1, 2, 3, 4)}, "restart");
        tick();
        chk({10'h0, tcOut}, {10'h0, tc(1, 2, 3, 5)}, "run on");
        $display("test jam done");
        // external mode: chase and delayed auto record, then a burst ends
        i_src.drop_tc();
        apb(1'b1, REG_DELAY, 32'h3);
        apb(1'b1, REG_CTRL, ctrlw(1'b1, 1'b1, 1'b0, 2'h0, 3'h5));
        i_src.drive_tc(tc(0, 4, 0, 5));
        cyc(3);
        chk({10'h0, tcOut}, {10'h0, tc(0, 4, 0, 5)}, "chase");
        tick();
        tick();
        chk({31'h0, recordGo}, 32'h0, "record early");
        tick();
        chk({31'h0, recordGo}, 32'h1, "record start");
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h0000_000d, "status while recording");
        i_src.drop_tc();
        cyc(2);
        chk({31'h0, recordGo}, 32'h0, "record stop");
        $display("test ext done");
        // rtc start: saved count advanced by elapsed seconds
        apb(1'b1, REG_CTRL, 32'h0);
        apb(1'b1, REG_SAVED, tcw(tc(0, 0, 8'h3a, 8'h0a)));
        apb(1'b1, REG_ELAPSED, 32'h0000_000a);
        apb(1'b1, REG_CTRL, ctrlw(1'b1, 1'b0, 1'b1, 2'h0, 3'h5));
        cyc(2);
        chk({31'h0, initBusy}, 32'h1, "advancing");
        for (int n = 0; n < 200 && initBusy !== 1'b0; n++) cyc(1);
        cyc(1);
        chk({10'h0, tcOut}, {10'h0, tc(0, 1, 8'h08, 8'h0a)}, "rtc start");
        $display("test rtc done");
        finish_test();
    end
endmodule : testbench
